/* rtl/limit_alert_pkg.sv */
// shared constants and types of the limit status and alert logic
`default_nettype none
package limit_alert_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_STATUS_PRI = 8'h41;
   localparam logic [7:0] OFS_STATUS_SEC = 8'h42;
   localparam logic [7:0] OFS_MASK_PRI = 8'h74;
   localparam logic [7:0] OFS_MASK_SEC = 8'h75;
   localparam logic [7:0] OFS_CFG_THREE = 8'h78;
   localparam logic [7:0] OFS_CFG_FOUR = 8'h7d;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SUMMARY_BIT = 7;
   localparam int REMOTE_TWO_BIT = 6;
   localparam int LOCAL_BIT = 5;
   localparam int REMOTE_ONE_BIT = 4;
   localparam int MAIN_SUPPLY_BIT = 2;
   localparam int CPU_SUPPLY_BIT = 1;
   localparam int CPU_MASK_BIT = 0;
   localparam int DIODE_TWO_BIT = 7;
   localparam int DIODE_ONE_BIT = 6;
   localparam int FAN_FOUR_BIT = 5;
   localparam int FAN_ONE_BIT = 2;
   localparam int OVERTEMP_BIT = 1;
   localparam int ALERT_EN_BIT = 0;
   localparam logic [7:0] STATUS_PRI_USED = 8'h76;
   localparam logic [7:0] STATUS_SEC_USED = 8'hfe;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;

   // ----------------------------------------------------------------
   // channels and pin functions
   // ----------------------------------------------------------------
   localparam int NUM_CH = 5;
   localparam int MEAS_W = 8;
   localparam int CH_CPU = 0;
   localparam int CH_MAIN = 1;
   localparam int CH_REMOTE_ONE = 2;
   localparam int CH_LOCAL = 3;
   localparam int CH_REMOTE_TWO = 4;

   typedef enum logic [1:0] {
      PIN9_SPEED = 2'b00,
      PIN9_HOT = 2'b01,
      PIN9_ALERT = 2'b10,
      PIN9_SPARE = 2'b11
   } pin9_func_t;

   typedef struct packed {
      logic valid;
      logic [MEAS_W-1:0] value;
      logic [MEAS_W-1:0] low;
      logic [MEAS_W-1:0] high;
   } meas_t;

   typedef struct packed {
      logic diode_two_fault;
      logic diode_one_fault;
      logic fan_four_slow;
      logic fan_three_slow;
      logic fan_two_slow;
      logic fan_one_slow;
      logic hot_timer_over;
      logic overtemp;
   } aux_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] cause_pri;
      logic [7:0] status_pri;
      logic [7:0] status_sec;
      logic [7:0] mask_pri;
      logic [7:0] mask_sec;
      logic alert_en;
      pin9_func_t pin9_func;
      logic [7:0] rdata;
      logic alert_n;
      logic pin5_oe_n;
      logic pin9_oe_n;
   } state_t;

endpackage
`default_nettype wire

/* rtl/limit_status_alert_logic.sv */
// sticky limit status registers, alert masking and alert pin selection
`timescale 1ns/1ps
`default_nettype none

//
// Behaviour
// - out-of-limit comparison sets channel status bit
// - status sticky, read clears only absent causes
// - primary bit 7 summarises secondary status
// - primary bits 6,5,4: remote two, local, remote one
// - primary bit 2 main, bit 1 cpu supply
// - secondary bits 7,6: diode two, one faults
// - secondary bit 5: fan four or hot timer
// - secondary bits 4,3,2: fans three, two, one
// - secondary bit 1: overtemperature limit exceeded
// - alert held while out, until status read
// - mask blocks alert only, status still sets
// - mask bit 7 secondary, bit 0 cpu
// - mask bits 6,5,4 temps, bit 2 main
// - secondary mask bits gate secondary sources
// - alert off at reset; config bit enables pin five
// - pin nine function field: speed, hot, alert
// - high is greater-than, low is less-or-equal
module limit_status_alert_logic (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic ARST_N,
   // register access
   input wire limit_alert_pkg::reg_req_t REG,
   output logic [7:0] REG_RDATA,
   // comparator sources
   input wire limit_alert_pkg::meas_t [limit_alert_pkg::NUM_CH-1:0] MEAS,
   input wire limit_alert_pkg::aux_t AUX,
   // alert and pins
   output logic ALERT_N,
   output logic PIN5_OUT,
   output logic PIN5_OE_N,
   output logic PIN9_OUT,
   output logic PIN9_OE_N
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic int ch_bit(input int ch);
      int b;
      b = limit_alert_pkg::CPU_SUPPLY_BIT;
      unique case (ch)
         limit_alert_pkg::CH_MAIN: b = limit_alert_pkg::MAIN_SUPPLY_BIT;
         limit_alert_pkg::CH_REMOTE_ONE: b = limit_alert_pkg::REMOTE_ONE_BIT;
         limit_alert_pkg::CH_LOCAL: b = limit_alert_pkg::LOCAL_BIT;
         limit_alert_pkg::CH_REMOTE_TWO: b = limit_alert_pkg::REMOTE_TWO_BIT;
         default: b = limit_alert_pkg::CPU_SUPPLY_BIT;
      endcase
      return b;
   endfunction

   // window comparison of one measurement
   function automatic logic out_of_limit(input limit_alert_pkg::meas_t m);
      return (m.value > m.high) || (m.value <= m.low);
   endfunction

   function automatic logic hits(input limit_alert_pkg::reg_req_t q, input logic [7:0] ofs);
      return q.addr == ofs;
   endfunction

   // mask aligned onto primary status positions
   function automatic logic [7:0] pri_mask_aligned(input logic [7:0] m);
      logic [7:0] a;
      a = m;
      a[limit_alert_pkg::CPU_SUPPLY_BIT] = m[limit_alert_pkg::CPU_MASK_BIT];
      a[limit_alert_pkg::CPU_MASK_BIT] = 1'b1;
      return a;
   endfunction

   function automatic logic alert_of(input limit_alert_pkg::state_t s);
      logic p;
      logic q;
      p = |(s.status_pri & ~pri_mask_aligned(s.mask_pri) & limit_alert_pkg::STATUS_PRI_USED);
      q = |(s.status_sec & ~s.mask_sec & limit_alert_pkg::STATUS_SEC_USED);
      return p | (q & ~s.mask_pri[limit_alert_pkg::SUMMARY_BIT]);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   limit_alert_pkg::state_t r;
   limit_alert_pkg::state_t n;
   logic [7:0] cause_pri;
   logic [7:0] cause_sec;
   logic rd_pri;
   logic rd_sec;
   logic alert;

   always_comb begin
      n = r;
      cause_pri = r.cause_pri;
      for (int i = 0; i < limit_alert_pkg::NUM_CH; i++) begin
         if (MEAS[i].valid) begin
            cause_pri[ch_bit(i)] = out_of_limit(MEAS[i]);
         end
      end
      cause_pri = cause_pri & limit_alert_pkg::STATUS_PRI_USED;
      n.cause_pri = cause_pri;

      cause_sec = 8'h00;
      cause_sec[limit_alert_pkg::DIODE_TWO_BIT] = AUX.diode_two_fault;
      cause_sec[limit_alert_pkg::DIODE_ONE_BIT] = AUX.diode_one_fault;
      cause_sec[limit_alert_pkg::FAN_ONE_BIT+2] = AUX.fan_three_slow;
      cause_sec[limit_alert_pkg::FAN_ONE_BIT+1] = AUX.fan_two_slow;
      cause_sec[limit_alert_pkg::FAN_ONE_BIT] = AUX.fan_one_slow;
      cause_sec[limit_alert_pkg::OVERTEMP_BIT] = AUX.overtemp;
      // shared bit follows pin nine function
      if (r.pin9_func == limit_alert_pkg::PIN9_HOT) begin
         cause_sec[limit_alert_pkg::FAN_FOUR_BIT] = AUX.hot_timer_over;
      end else begin
         cause_sec[limit_alert_pkg::FAN_FOUR_BIT] = AUX.fan_four_slow;
      end

      rd_pri = REG.rd && hits(REG, limit_alert_pkg::OFS_STATUS_PRI);
      rd_sec = REG.rd && hits(REG, limit_alert_pkg::OFS_STATUS_SEC);

      // read clears absent causes, set wins
      n.status_pri = ((r.status_pri & ~({8{rd_pri}} & ~cause_pri)) | cause_pri)
                     & limit_alert_pkg::STATUS_PRI_USED;
      n.status_sec = ((r.status_sec & ~({8{rd_sec}} & ~cause_sec)) | cause_sec)
                     & limit_alert_pkg::STATUS_SEC_USED;

      // register writes
      if (REG.wr) begin
         unique case (REG.addr)
            limit_alert_pkg::OFS_MASK_PRI: n.mask_pri = REG.wdata;
            limit_alert_pkg::OFS_MASK_SEC: n.mask_sec = REG.wdata;
            limit_alert_pkg::OFS_CFG_THREE: n.alert_en = REG.wdata[limit_alert_pkg::ALERT_EN_BIT];
            limit_alert_pkg::OFS_CFG_FOUR: n.pin9_func = limit_alert_pkg::pin9_func_t'(REG.wdata[1:0]);
            default: n.mask_pri = r.mask_pri;
         endcase
      end

      // register reads, unmapped read as zero
      if (REG.rd) begin
         unique case (REG.addr)
            limit_alert_pkg::OFS_STATUS_PRI: n.rdata = {|r.status_sec, r.status_pri[6:0]};
            limit_alert_pkg::OFS_STATUS_SEC: n.rdata = r.status_sec;
            limit_alert_pkg::OFS_MASK_PRI: n.rdata = r.mask_pri;
            limit_alert_pkg::OFS_MASK_SEC: n.rdata = r.mask_sec;
            limit_alert_pkg::OFS_CFG_THREE: n.rdata = {7'h00, r.alert_en};
            limit_alert_pkg::OFS_CFG_FOUR: n.rdata = {6'h00, r.pin9_func};
            default: n.rdata = 8'h00;
         endcase
      end

      alert = alert_of(n);
      n.alert_n = ~alert;
      n.pin5_oe_n = ~(n.alert_en & alert);
      n.pin9_oe_n = ~((n.pin9_func == limit_alert_pkg::PIN9_ALERT) & alert);
   end

   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r.cause_pri <= limit_alert_pkg::STATUS_RST;
         r.status_pri <= limit_alert_pkg::STATUS_RST;
         r.status_sec <= limit_alert_pkg::STATUS_RST;
         r.mask_pri <= limit_alert_pkg::MASK_RST;
         r.mask_sec <= limit_alert_pkg::MASK_RST;
         r.alert_en <= 1'b0;
         r.pin9_func <= limit_alert_pkg::PIN9_SPEED;
         r.rdata <= limit_alert_pkg::RDATA_RST;
         r.alert_n <= 1'b1;
         r.pin5_oe_n <= 1'b1;
         r.pin9_oe_n <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign REG_RDATA = r.rdata;
   assign ALERT_N = r.alert_n;
   assign PIN5_OUT = r.alert_n;
   assign PIN5_OE_N = r.pin5_oe_n;
   assign PIN9_OUT = r.alert_n;
   assign PIN9_OE_N = r.pin9_oe_n;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_read_pri;
      REG.rd && REG.addr == limit_alert_pkg::OFS_STATUS_PRI;
   endsequence

   sequence s_remote_one_bad;
      MEAS[limit_alert_pkg::CH_REMOTE_ONE].valid && out_of_limit(MEAS[limit_alert_pkg::CH_REMOTE_ONE]);
   endsequence

   sequence s_read_sec;
      REG.rd && REG.addr == limit_alert_pkg::OFS_STATUS_SEC;
   endsequence

   property p_cpu_set;
      @(posedge REF_CLK) disable iff (!ARST_N)
      MEAS[limit_alert_pkg::CH_CPU].valid && (MEAS[limit_alert_pkg::CH_CPU].value
         > MEAS[limit_alert_pkg::CH_CPU].high) |=> r.status_pri[limit_alert_pkg::CPU_SUPPLY_BIT];
   endproperty
   a_cpu_set: assert property (p_cpu_set) else $error("cpu supply status not set");

   property p_low_edge;
      @(posedge REF_CLK) disable iff (!ARST_N)
      MEAS[limit_alert_pkg::CH_LOCAL].valid && (MEAS[limit_alert_pkg::CH_LOCAL].value
         == MEAS[limit_alert_pkg::CH_LOCAL].low) |=> r.status_pri[limit_alert_pkg::LOCAL_BIT];
   endproperty
   a_low_edge: assert property (p_low_edge) else $error("low limit equality not flagged");

   property p_sticky;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.status_pri[limit_alert_pkg::REMOTE_ONE_BIT] && !(REG.rd && REG.addr == limit_alert_pkg::OFS_STATUS_PRI)
         |=> r.status_pri[limit_alert_pkg::REMOTE_ONE_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit dropped without read");

   property p_read_clear;
      @(posedge REF_CLK) disable iff (!ARST_N)
      s_read_pri and (!MEAS[limit_alert_pkg::CH_REMOTE_ONE].valid
         && !r.cause_pri[limit_alert_pkg::REMOTE_ONE_BIT]) |=> !r.status_pri[limit_alert_pkg::REMOTE_ONE_BIT];
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("absent cause not cleared by read");

   property p_read_set_wins;
      @(posedge REF_CLK) disable iff (!ARST_N)
      s_read_pri and s_remote_one_bad |=> r.status_pri[limit_alert_pkg::REMOTE_ONE_BIT][*2];
   endproperty
   a_read_set_wins: assert property (p_read_set_wins) else $error("new event lost during read");

   property p_summary;
      @(posedge REF_CLK) disable iff (!ARST_N)
      s_read_pri |=> REG_RDATA[limit_alert_pkg::SUMMARY_BIT] == (|$past(r.status_sec));
   endproperty
   a_summary: assert property (p_summary) else $error("summary bit wrong");

   property p_fan_one;
      @(posedge REF_CLK) disable iff (!ARST_N)
      AUX.fan_one_slow |=> r.status_sec[limit_alert_pkg::FAN_ONE_BIT];
   endproperty
   a_fan_one: assert property (p_fan_one) else $error("fan one status not set");

   property p_hot_select;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.pin9_func == limit_alert_pkg::PIN9_HOT && AUX.hot_timer_over && !AUX.fan_four_slow
         |=> r.status_sec[limit_alert_pkg::FAN_FOUR_BIT];
   endproperty
   a_hot_select: assert property (p_hot_select) else $error("hot timer event not flagged");

   property p_masked_sets;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.mask_sec[limit_alert_pkg::DIODE_ONE_BIT] && AUX.diode_one_fault
         |=> r.status_sec[limit_alert_pkg::DIODE_ONE_BIT];
   endproperty
   a_masked_sets: assert property (p_masked_sets) else $error("masked source did not set status");

   property p_alert_level;
      @(posedge REF_CLK) disable iff (!ARST_N)
      !ALERT_N == ((|(r.status_pri & ~r.mask_pri & limit_alert_pkg::STATUS_PRI_USED
         & ~(8'h01 << limit_alert_pkg::CPU_SUPPLY_BIT)))
         || (r.status_pri[limit_alert_pkg::CPU_SUPPLY_BIT] && !r.mask_pri[limit_alert_pkg::CPU_MASK_BIT])
         || ((|(r.status_sec & ~r.mask_sec & limit_alert_pkg::STATUS_SEC_USED))
         && !r.mask_pri[limit_alert_pkg::SUMMARY_BIT]));
   endproperty
   a_alert_level: assert property (p_alert_level) else $error("alert disagrees with unmasked status");

   property p_pin5_gate;
      @(posedge REF_CLK) disable iff (!ARST_N)
      !PIN5_OE_N |-> r.alert_en && !ALERT_N;
   endproperty
   a_pin5_gate: assert property (p_pin5_gate) else $error("pin five driven while disabled");

   property p_pin9_gate;
      @(posedge REF_CLK) disable iff (!ARST_N)
      !PIN9_OE_N |-> r.pin9_func == limit_alert_pkg::PIN9_ALERT && !ALERT_N;
   endproperty
   a_pin9_gate: assert property (p_pin9_gate) else $error("pin nine driven in wrong function");

   property p_remote_two_high;
      @(posedge REF_CLK) disable iff (!ARST_N)
      MEAS[limit_alert_pkg::CH_REMOTE_TWO].valid && (MEAS[limit_alert_pkg::CH_REMOTE_TWO].value
         > MEAS[limit_alert_pkg::CH_REMOTE_TWO].high) |=> r.status_pri[limit_alert_pkg::REMOTE_TWO_BIT];
   endproperty
   a_remote_two_high: assert property (p_remote_two_high) else $error("remote two status not set");

   property p_main_low;
      @(posedge REF_CLK) disable iff (!ARST_N)
      MEAS[limit_alert_pkg::CH_MAIN].valid && (MEAS[limit_alert_pkg::CH_MAIN].value
         <= MEAS[limit_alert_pkg::CH_MAIN].low) |=> r.status_pri[limit_alert_pkg::MAIN_SUPPLY_BIT];
   endproperty
   a_main_low: assert property (p_main_low) else $error("main supply status not set");

   property p_diode_two;
      @(posedge REF_CLK) disable iff (!ARST_N)
      AUX.diode_two_fault |=> r.status_sec[limit_alert_pkg::DIODE_TWO_BIT];
   endproperty
   a_diode_two: assert property (p_diode_two) else $error("diode two fault not flagged");

   property p_fan_four;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.pin9_func != limit_alert_pkg::PIN9_HOT && AUX.fan_four_slow
         |=> r.status_sec[limit_alert_pkg::FAN_FOUR_BIT];
   endproperty
   a_fan_four: assert property (p_fan_four) else $error("fan four status not set");

   property p_sec_sticky;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.status_sec[limit_alert_pkg::FAN_ONE_BIT] && !(REG.rd && REG.addr == limit_alert_pkg::OFS_STATUS_SEC)
         |=> r.status_sec[limit_alert_pkg::FAN_ONE_BIT];
   endproperty
   a_sec_sticky: assert property (p_sec_sticky) else $error("secondary bit dropped without read");

   property p_sec_clear;
      @(posedge REF_CLK) disable iff (!ARST_N)
      s_read_sec and !AUX.fan_one_slow |=> !r.status_sec[limit_alert_pkg::FAN_ONE_BIT];
   endproperty
   a_sec_clear: assert property (p_sec_clear) else $error("secondary bit not cleared by read");

   property p_cfg_three;
      @(posedge REF_CLK) disable iff (!ARST_N)
      REG.wr && REG.addr == limit_alert_pkg::OFS_CFG_THREE
         |=> r.alert_en == $past(REG.wdata[limit_alert_pkg::ALERT_EN_BIT]);
   endproperty
   a_cfg_three: assert property (p_cfg_three) else $error("alert enable not stored");

   property p_summary_mask;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.mask_pri[limit_alert_pkg::SUMMARY_BIT] && r.status_pri == limit_alert_pkg::STATUS_RST |-> ALERT_N;
   endproperty
   a_summary_mask: assert property (p_summary_mask) else $error("secondary alert not suppressed");

   property p_pin5_drive;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.alert_en && !ALERT_N |-> !PIN5_OE_N;
   endproperty
   a_pin5_drive: assert property (p_pin5_drive) else $error("pin five not driven on alert");

   property p_pin9_drive;
      @(posedge REF_CLK) disable iff (!ARST_N)
      r.pin9_func == limit_alert_pkg::PIN9_ALERT && !ALERT_N |-> !PIN9_OE_N;
   endproperty
   a_pin9_drive: assert property (p_pin9_drive) else $error("pin nine not driven on alert");

endmodule
`default_nettype wire

/* verif/limit_status_alert_logic_tb.sv */
// self-checking bench of the limit status and alert logic
`timescale 1ns/1ps
`default_nettype none
module limit_status_alert_logic_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   limit_alert_pkg::reg_req_t req;
   logic [7:0] rdata;
   limit_alert_pkg::meas_t [limit_alert_pkg::NUM_CH-1:0] meas;
   limit_alert_pkg::aux_t aux;
   logic alert_n, p5_out, p5_oe_n, p9_out, p9_oe_n;
   int bad_count = 0;
   int num_checks = 0;
   logic [7:0] rd, pri, sec;
   int pri_pos[5] = '{1, 2, 4, 5, 6};
   int msk_pos[5] = '{0, 2, 4, 5, 6};
   int aux_pos[7] = '{7, 6, 5, 4, 3, 2, 0};
   int sec_pos[7] = '{7, 6, 5, 4, 3, 2, 1};
   logic [7:0] regs[7] = '{8'h41, 8'h42, 8'h74, 8'h75, 8'h78, 8'h7d, 8'h33};

   always #5 clk = ~clk;

   limit_status_alert_logic i_limit_status_alert_logic (
      .REF_CLK(clk), .ARST_N(arst_n), .REG(req), .REG_RDATA(rdata), .MEAS(meas), .AUX(aux),
      .ALERT_N(alert_n), .PIN5_OUT(p5_out), .PIN5_OE_N(p5_oe_n), .PIN9_OUT(p9_out), .PIN9_OE_N(p9_oe_n)
   );
   reg_host_model i_reg_host_model (.clk(clk), .req(req), .rdata(rdata));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_host_model.access(1'b0, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_reg_host_model.read_reg(a, rd);
      check(rd, exp);
   endtask
   // one comparison against fixed limits low 0x10, high 0x80
   task automatic meas_pulse(input int ch, input logic [7:0] v);
      @(posedge clk);
      #1;
      meas[ch] = '{valid: 1'b1, value: v, low: 8'h10, high: 8'h80};
      @(posedge clk);
      #1;
      meas[ch].valid = 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // expected {alert_n, p5_oe_n, p9_oe_n}, enables active low; open-drain data copies the alert
   task automatic pins_chk(input logic [2:0] e);
      repeat (2) @(posedge clk);
      #1;
      check({3'h0, alert_n, p5_oe_n, p9_oe_n, p5_out, p9_out}, {3'h0, e, e[2], e[2]});
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      meas = '0;
      aux = '0;
      repeat (8) @(posedge clk);
      #1;
      arst_n = 1'b1;
      pins_chk(3'b111);
      foreach (regs[k]) rd_chk(regs[k], 8'h00);
      wr(8'h74, 8'ha5);
      rd_chk(8'h74, 8'ha5);
      wr(8'h75, 8'h5a);
      rd_chk(8'h75, 8'h5a);
      wr(8'h41, 8'hff);
      rd_chk(8'h41, 8'h00);
      wr(8'h74, 8'h00);
      wr(8'h75, 8'h00);
      wr(8'h78, 8'h01);
      for (int ch = 0; ch < 5; ch++) begin
         meas_pulse(ch, 8'h80);
         rd_chk(8'h41, 8'h00);
         wr(8'h74, 8'h01 << msk_pos[ch]);
         meas_pulse(ch, 8'h10);
         pins_chk(3'b111);
         rd_chk(8'h41, 8'h01 << pri_pos[ch]);
         wr(8'h74, 8'h00);
         pins_chk(3'b001);
         meas_pulse(ch, 8'h81);
         rd_chk(8'h41, 8'h01 << pri_pos[ch]);
         meas_pulse(ch, 8'h40);
         pins_chk(3'b001);
         rd_chk(8'h41, 8'h01 << pri_pos[ch]);
         rd_chk(8'h41, 8'h00);
         pins_chk(3'b111);
      end
      // event landing on a status read survives it
      fork
         meas_pulse(2, 8'hf0);
         rd_chk(8'h41, 8'h00);
      join
      rd_chk(8'h41, 8'h10);
      meas_pulse(2, 8'h40);
      rd_chk(8'h41, 8'h10);
      rd_chk(8'h41, 8'h00);
      for (int k = 0; k < 7; k++) begin
         wr(8'h75, 8'h01 << sec_pos[k]);
         aux = limit_alert_pkg::aux_t'(8'h01 << aux_pos[k]);
         pins_chk(3'b111);
         wr(8'h75, 8'h00);
         wr(8'h74, 8'h80);
         pins_chk(3'b111);
         wr(8'h74, 8'h00);
         pins_chk(3'b001);
         i_reg_host_model.service(pri, sec);
         check(pri, 8'h80);
         check(sec, 8'h01 << sec_pos[k]);
         aux = '0;
         rd_chk(8'h42, 8'h01 << sec_pos[k]);
         rd_chk(8'h42, 8'h00);
         rd_chk(8'h41, 8'h00);
         pins_chk(3'b111);
      end
      aux.hot_timer_over = 1'b1;
      rd_chk(8'h42, 8'h00);
      wr(8'h7d, 8'h01);
      rd_chk(8'h42, 8'h20);
      aux = '0;
      rd_chk(8'h42, 8'h20);
      rd_chk(8'h42, 8'h00);
      wr(8'h7d, 8'h02);
      wr(8'h78, 8'h00);
      meas_pulse(3, 8'h05);
      pins_chk(3'b010);
      wr(8'h7d, 8'h00);
      pins_chk(3'b011);
      // mid-run reset returns every register to idle
      wr(8'h74, 8'hff);
      @(posedge clk);
      #1;
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      arst_n = 1'b1;
      pins_chk(3'b111);
      foreach (regs[k]) rd_chk(regs[k], 8'h00);
      summarize();
   end

   initial begin
      #100000;
      bad_count++;
      summarize();
   end
endmodule
`default_nettype wire

/* verif/reg_host_model.sv */
// supervisor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
   // clock
   input wire logic clk,
   // register port
   output var limit_alert_pkg::reg_req_t req,
   input wire logic [7:0] rdata
);
   initial begin
      req = '0;
   end
   task automatic access(input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      req = '{rd: r, wr: ~r, addr: a, wdata: d};
      @(posedge clk);
      #1;
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      access(1'b1, a, 8'h00);
      d = rdata;
   endtask
   task automatic service(output logic [7:0] pri, output logic [7:0] sec);
      read_reg(limit_alert_pkg::OFS_STATUS_PRI, pri);
      sec = 8'h00;
      if (pri[7] === 1'b1) begin
         read_reg(limit_alert_pkg::OFS_STATUS_SEC, sec);
      end
   endtask
endmodule
`default_nettype wire
